// >>> core/bcrtc_core.v
// BCD calendar clock with alarm and periodic tick, host field port.
// Assumes host port inputs synchronous to clk; crystal input is
// resynchronised here and must be far slower than clk.
`timescale 1ns/1ps
`include "bcrtc_consts.vh"

////////////////////////////////////////////////////////////////////////
module bcrtc_core (
	// Clock and reset
	input  wire        clk,
	input  wire        reset,
	// Crystal and supply
	input  wire        xtalIn,
	input  wire        mainPowerGood,
	// Write request
	input  wire        wrEn,
	input  wire [4:0]  wrAddr,
	input  wire [7:0]  wrData,
	// Read request and collect
	input  wire        rdStart,
	input  wire        rdTake,
	input  wire [4:0]  rdAddr,
	output reg  [7:0]  rdData_q,
	output reg         rdReady_q,
	// Status
	output wire        accessBlocked,
	output reg         alarmIrq_q,
	output reg         tickIrq_q
);

	////////////////////////////////////////////////////////////////////
	// BCD increment of a two-digit byte, 99 wraps to 00
	function [7:0] bcdInc;
		input [7:0] v;
		begin
			if (v[3:0] == `BCRTC_NIB_9) begin
				if (v[7:4] == `BCRTC_NIB_9)
					bcdInc = {`BCRTC_NIB_0, `BCRTC_NIB_0};
				else
					bcdInc = {v[7:4] + `BCRTC_NIB_1, `BCRTC_NIB_0};
			end else begin
				bcdInc = {v[7:4], v[3:0] + `BCRTC_NIB_1};
			end
		end
	endfunction

	// Prescaler bits that must all be set for a tick of each period
	function [14:0] tickMask;
		input [2:0] sel;
		begin
			case (sel)
				`BCRTC_T_256: tickMask = `BCRTC_M_256;
				`BCRTC_T_64:  tickMask = `BCRTC_M_64;
				`BCRTC_T_16:  tickMask = `BCRTC_M_16;
				`BCRTC_T_4:   tickMask = `BCRTC_M_4;
				`BCRTC_T_2:   tickMask = `BCRTC_M_2;
				default:      tickMask = `BCRTC_PRE_FULL;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// State
	reg  [7:0]  ctrl_q;
	reg  [7:0]  almCtrl_q;
	reg  [7:0]  alarm_irq_select_q;
	reg         alarmFlag_q;
	reg         tickFlag_q;
	reg  [7:0]  timeVal_q [0:7];
	reg  [7:0]  almVal_q  [0:7];
	reg         xtalSync1_q;
	reg         xtalSync2_q;
	reg         xtalPrev_q;
	reg  [14:0] prescale_q;
	reg         secUpdate_q;
	reg  [7:0]  rdMux;

	wire        xtalRise;
	wire        secTick;
	wire        tickHit;
	wire        runEn;
	wire        wrOk;
	wire        rdOk;
	wire        wrTime;
	wire        wrAlm;
	wire [4:0]  wrTimeIdx;
	wire [4:0]  wrAlmIdx;
	wire [7:0]  lastDate;
	wire        secWrap;
	wire        minWrap;
	wire        hourWrap;
	wire        dateWrap;
	wire        monWrap;
	wire        ylWrap;
	wire [7:0]  fieldOk;
	wire        alarmHit;
	wire        alarmClr;
	wire        tickClr;
	wire [15:0] yearNow;
	wire [4:0]  rdTimeIdx;
	wire [4:0]  rdAlmIdx;

	////////////////////////////////////////////////////////////////////
	// Host access gating
	assign accessBlocked = ~mainPowerGood;
	assign wrOk = wrEn & mainPowerGood & (ctrl_q[`BCRTC_CTRL_IFEN] | (wrAddr == `BCRTC_A_CTRL));
	assign rdOk = rdStart & mainPowerGood & ctrl_q[`BCRTC_CTRL_IFEN];
	assign wrTime = wrOk & (wrAddr >= `BCRTC_A_SEC) & (wrAddr <= `BCRTC_A_YHI);
	assign wrAlm = wrOk & (wrAddr >= `BCRTC_A_ASEC) & (wrAddr <= `BCRTC_A_AYHI);
	assign wrTimeIdx = wrAddr - `BCRTC_A_SEC;
	assign wrAlmIdx = wrAddr - `BCRTC_A_ASEC;
	assign runEn = ctrl_q[`BCRTC_CTRL_RUN];

	////////////////////////////////////////////////////////////////////
	// Crystal timebase
	assign xtalRise = xtalSync2_q & ~xtalPrev_q;
	assign secTick = xtalRise & (prescale_q == `BCRTC_PRE_FULL);
	assign tickHit = xtalRise & ((prescale_q & tickMask(alarm_irq_select_q[`BCRTC_IM_TSEL_HI:`BCRTC_IM_TSEL_LO]))
		== tickMask(alarm_irq_select_q[`BCRTC_IM_TSEL_HI:`BCRTC_IM_TSEL_LO]));

	// Divider runs from the crystal regardless of host power state
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			xtalSync1_q <= 1'b0;
			xtalSync2_q <= 1'b0;
			xtalPrev_q <= 1'b0;
			prescale_q <= `BCRTC_PRE_ZERO;
		end else begin
			xtalSync1_q <= xtalIn;
			xtalSync2_q <= xtalSync1_q;
			xtalPrev_q <= xtalSync2_q;
			if (!runEn)
				prescale_q <= `BCRTC_PRE_ZERO;
			else if (xtalRise)
				prescale_q <= prescale_q + 15'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Calendar counters
	bcrtc_month_end bcrtc_month_end_i (
		.month    (timeVal_q[`BCRTC_I_MON]),
		.year     (yearNow),
		.lastDate (lastDate)
	);

	assign yearNow = {timeVal_q[`BCRTC_I_YHI], timeVal_q[`BCRTC_I_YLO]};
	assign secWrap = timeVal_q[`BCRTC_I_SEC] == `BCRTC_B_59;
	assign minWrap = secWrap & (timeVal_q[`BCRTC_I_MIN] == `BCRTC_B_59);
	assign hourWrap = minWrap & (timeVal_q[`BCRTC_I_HOUR] == `BCRTC_B_23);
	assign dateWrap = hourWrap & (timeVal_q[`BCRTC_I_DATE] == lastDate);
	assign monWrap = dateWrap & (timeVal_q[`BCRTC_I_MON] == `BCRTC_B_12);
	assign ylWrap = monWrap & (timeVal_q[`BCRTC_I_YLO] == `BCRTC_B_99);

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			timeVal_q[`BCRTC_I_SEC] <= `BCRTC_B_ZERO;
			timeVal_q[`BCRTC_I_MIN] <= `BCRTC_B_ZERO;
			timeVal_q[`BCRTC_I_HOUR] <= `BCRTC_B_ZERO;
			timeVal_q[`BCRTC_I_DATE] <= `BCRTC_B_ONE;
			timeVal_q[`BCRTC_I_WDAY] <= `BCRTC_B_ONE;
			timeVal_q[`BCRTC_I_MON] <= `BCRTC_B_ONE;
			timeVal_q[`BCRTC_I_YLO] <= `BCRTC_B_ZERO;
			timeVal_q[`BCRTC_I_YHI] <= `BCRTC_YHI_RST;
			secUpdate_q <= 1'b0;
		end else begin
			secUpdate_q <= secTick & runEn;
			if (secTick && runEn) begin
				timeVal_q[`BCRTC_I_SEC] <= secWrap ? `BCRTC_B_ZERO : bcdInc(timeVal_q[`BCRTC_I_SEC]);
				if (secWrap)
					timeVal_q[`BCRTC_I_MIN] <= minWrap ? `BCRTC_B_ZERO : bcdInc(timeVal_q[`BCRTC_I_MIN]);
				if (minWrap)
					timeVal_q[`BCRTC_I_HOUR] <= hourWrap ? `BCRTC_B_ZERO : bcdInc(timeVal_q[`BCRTC_I_HOUR]);
				if (hourWrap) begin
					timeVal_q[`BCRTC_I_WDAY] <= (timeVal_q[`BCRTC_I_WDAY] == `BCRTC_B_WDMAX) ?
						`BCRTC_B_ONE : bcdInc(timeVal_q[`BCRTC_I_WDAY]);
					timeVal_q[`BCRTC_I_DATE] <= dateWrap ? `BCRTC_B_ONE : bcdInc(timeVal_q[`BCRTC_I_DATE]);
				end
				if (dateWrap)
					timeVal_q[`BCRTC_I_MON] <= monWrap ? `BCRTC_B_ONE : bcdInc(timeVal_q[`BCRTC_I_MON]);
				if (monWrap)
					timeVal_q[`BCRTC_I_YLO] <= bcdInc(timeVal_q[`BCRTC_I_YLO]);
				if (ylWrap)
					timeVal_q[`BCRTC_I_YHI] <= bcdInc(timeVal_q[`BCRTC_I_YHI]);
			end
			// A host write to a field wins over a carry in the same cycle
			if (wrTime)
				timeVal_q[wrTimeIdx[2:0]] <= wrData;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Control, alarm and interrupt registers
	always @(posedge clk or posedge reset) begin : regs
		integer i;
		if (reset) begin
			ctrl_q <= `BCRTC_CTRL_RST;
			almCtrl_q <= `BCRTC_B_ZERO;
			alarm_irq_select_q <= `BCRTC_B_ZERO;
			for (i = 0; i < `BCRTC_NFIELD; i = i + 1)
				almVal_q[i] <= `BCRTC_B_ZERO;
		end else begin
			if (wrOk && (wrAddr == `BCRTC_A_CTRL))
				ctrl_q <= wrData;
			if (wrOk && (wrAddr == `BCRTC_A_ALMCTRL))
				almCtrl_q <= wrData;
			if (wrOk && (wrAddr == `BCRTC_A_IMODE))
				alarm_irq_select_q <= wrData;
			if (wrAlm)
				almVal_q[wrAlmIdx[2:0]] <= wrData;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Alarm compare: an unarmed field always matches
	genvar g;
	generate
		for (g = 0; g < `BCRTC_NFIELD; g = g + 1) begin : gCmp
			if (g >= `BCRTC_I_YLO) begin : gYear
				assign fieldOk[g] = ~almCtrl_q[`BCRTC_ALM_YEAR] | (timeVal_q[g] == almVal_q[g]);
			end else begin : gField
				assign fieldOk[g] = ~almCtrl_q[g] | (timeVal_q[g] == almVal_q[g]);
			end
		end
	endgenerate

	// Compared once per new second so a cleared flag is not re-raised
	assign alarmHit = secUpdate_q & almCtrl_q[`BCRTC_ALM_EN] & alarm_irq_select_q[`BCRTC_IM_ALMSEL] & (&fieldOk);
	assign alarmClr = wrOk & (wrAddr == `BCRTC_A_IFLAG) & wrData[`BCRTC_IF_ALARM];
	assign tickClr = wrOk & (wrAddr == `BCRTC_A_IFLAG) & wrData[`BCRTC_IF_TICK];

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			alarmFlag_q <= 1'b0;
			tickFlag_q <= 1'b0;
			alarmIrq_q <= 1'b0;
			tickIrq_q <= 1'b0;
		end else begin
			alarmFlag_q <= alarmHit | (alarmFlag_q & ~alarmClr);
			tickFlag_q <= (tickHit & alarm_irq_select_q[`BCRTC_IM_TICKEN]) | (tickFlag_q & ~tickClr);
			alarmIrq_q <= alarmHit | (alarmFlag_q & ~alarmClr);
			tickIrq_q <= tickHit & alarm_irq_select_q[`BCRTC_IM_TICKEN];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read: start captures the field, collect releases it
	assign rdTimeIdx = rdAddr - `BCRTC_A_SEC;
	assign rdAlmIdx = rdAddr - `BCRTC_A_ASEC;

	always @* begin
		rdMux = `BCRTC_B_ZERO;
		if (rdAddr == `BCRTC_A_CTRL)
			rdMux = ctrl_q;
		else if ((rdAddr >= `BCRTC_A_SEC) && (rdAddr <= `BCRTC_A_YHI))
			rdMux = timeVal_q[rdTimeIdx[2:0]];
		else if (rdAddr == `BCRTC_A_ALMCTRL)
			rdMux = almCtrl_q;
		else if ((rdAddr >= `BCRTC_A_ASEC) && (rdAddr <= `BCRTC_A_AYHI))
			rdMux = almVal_q[rdAlmIdx[2:0]];
		else if (rdAddr == `BCRTC_A_IMODE)
			rdMux = alarm_irq_select_q;
		else if (rdAddr == `BCRTC_A_IFLAG)
			rdMux = {6'h00, tickFlag_q, alarmFlag_q};
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			rdData_q <= `BCRTC_B_ZERO;
			rdReady_q <= 1'b0;
		end else begin
			if (rdOk) begin
				rdData_q <= rdMux;
				rdReady_q <= 1'b1;
			end else if (rdTake) begin
				rdReady_q <= 1'b0;
			end
		end
	end

endmodule

// >>> core/bcrtc_consts.vh
// Constants for the BCD calendar clock: field addresses, bit positions,
// reset values and BCD limits.
// Assumes inclusion by bare name from every design file of the block.
`ifndef BCRTC_CONSTS_VH
`define BCRTC_CONSTS_VH

// System clock 40 MHz, crystal 32.768 kHz sampled on it
`define BCRTC_CLK_PERIOD_NS  25
`define BCRTC_XTAL_HZ        32768
`define BCRTC_PRE_W          15
`define BCRTC_PRE_ZERO       15'h0000
`define BCRTC_PRE_FULL       15'h7fff

// Field addresses on the host port
`define BCRTC_AW             5
`define BCRTC_A_CTRL         5'h00
`define BCRTC_A_SEC          5'h01
`define BCRTC_A_YHI          5'h08
`define BCRTC_A_ALMCTRL      5'h09
`define BCRTC_A_ASEC         5'h0a
`define BCRTC_A_AYHI         5'h11
`define BCRTC_A_IMODE        5'h12
`define BCRTC_A_IFLAG        5'h13

// Index of each field inside the time and alarm arrays
`define BCRTC_I_SEC          0
`define BCRTC_I_MIN          1
`define BCRTC_I_HOUR         2
`define BCRTC_I_DATE         3
`define BCRTC_I_WDAY         4
`define BCRTC_I_MON          5
`define BCRTC_I_YLO          6
`define BCRTC_I_YHI          7
`define BCRTC_NFIELD         8

// clock_control_reg bits
`define BCRTC_CTRL_RUN       0
`define BCRTC_CTRL_IFEN      1
`define BCRTC_CTRL_RST       8'h01

// alarm_control_reg: bits 6..0 arm a field, bit 7 enables the alarm
`define BCRTC_ALM_YEAR       6
`define BCRTC_ALM_EN         7

// interrupt_mode_reg bits
`define BCRTC_IM_ALMSEL      0
`define BCRTC_IM_TICKEN      1
`define BCRTC_IM_TSEL_LO     2
`define BCRTC_IM_TSEL_HI     4

// interrupt_flag_reg bits
`define BCRTC_IF_ALARM       0
`define BCRTC_IF_TICK        1

// Tick period select codes
`define BCRTC_T_256          3'h0
`define BCRTC_T_64           3'h1
`define BCRTC_T_16           3'h2
`define BCRTC_T_4            3'h3
`define BCRTC_T_2            3'h4
`define BCRTC_M_256          15'h007f
`define BCRTC_M_64           15'h01ff
`define BCRTC_M_16           15'h07ff
`define BCRTC_M_4            15'h1fff
`define BCRTC_M_2            15'h3fff

// BCD limits and reset values
`define BCRTC_B_ZERO         8'h00
`define BCRTC_B_ONE          8'h01
`define BCRTC_B_59           8'h59
`define BCRTC_B_23           8'h23
`define BCRTC_B_WDMAX        8'h07
`define BCRTC_B_12           8'h12
`define BCRTC_B_99           8'h99
`define BCRTC_B_28           8'h28
`define BCRTC_B_29           8'h29
`define BCRTC_B_30           8'h30
`define BCRTC_B_31           8'h31
`define BCRTC_B_FEB          8'h02
`define BCRTC_B_APR          8'h04
`define BCRTC_B_JUN          8'h06
`define BCRTC_B_SEP          8'h09
`define BCRTC_B_NOV          8'h11
`define BCRTC_YHI_RST        8'h20
`define BCRTC_NIB_9          4'h9
`define BCRTC_NIB_0          4'h0
`define BCRTC_NIB_1          4'h1

`endif

// >>> core/bcrtc_month_end.v
// Last date of the current month in BCD, leap years included.
// Assumes BCD month 01..12 and a four-digit BCD year.
`timescale 1ns/1ps
`include "bcrtc_consts.vh"

module bcrtc_month_end (
	// Calendar inputs
	input  wire [7:0]  month,
	input  wire [15:0] year,
	// Result
	output reg  [7:0]  lastDate
);

	// A BCD byte is a multiple of four when even tens pair with 0/4/8
	// and odd tens pair with 2/6
	function isMul4;
		input [7:0] b;
		begin
			if (b[4])
				isMul4 = (b[3:0] == 4'h2) || (b[3:0] == 4'h6);
			else
				isMul4 = (b[3:0] == 4'h0) || (b[3:0] == 4'h4) || (b[3:0] == 4'h8);
		end
	endfunction

	wire leapYear;

	assign leapYear = (year[7:0] == `BCRTC_B_ZERO) ? isMul4(year[15:8]) : isMul4(year[7:0]);

	always @* begin
		case (month)
			`BCRTC_B_FEB: lastDate = leapYear ? `BCRTC_B_29 : `BCRTC_B_28;
			`BCRTC_B_APR,
			`BCRTC_B_JUN,
			`BCRTC_B_SEP,
			`BCRTC_B_NOV: lastDate = `BCRTC_B_30;
			default: lastDate = `BCRTC_B_31;
		endcase
	end

endmodule

// >>> sim/bcrtc_core_properties.sv
// Concurrent checks on the host port, tick pulse and alarm line of bcrtc_core.
// Assumes only the top-level ports are visible; bound from the foot of this file.
`timescale 1ns/1ps
module bcrtc_core_properties (
	// Clock and reset
	input wire       clk,
	input wire       reset,
	// Host side
	input wire       mainPowerGood,
	input wire       wrEn,
	input wire [4:0] wrAddr,
	input wire [7:0] wrData,
	input wire       rdStart,
	input wire       rdTake,
	// Design outputs
	input wire [7:0] rdData_q,
	input wire       rdReady_q,
	input wire       accessBlocked,
	input wire       alarmIrq_q,
	input wire       tickIrq_q
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	wire flagClr = wrEn && mainPowerGood && wrAddr == 5'h13 && wrData[0];

	AST_RD_ANSWER: assert property ($rose(rdReady_q) |-> $past(rdStart && mainPowerGood))
		else $error("read ready without an accepted start");
	AST_RD_HOLD: assert property (rdReady_q && !rdTake |=> rdReady_q)
		else $error("read ready dropped without collect");
	AST_RD_TAKE: assert property (rdTake && !rdStart |=> !rdReady_q)
		else $error("read ready kept after collect");
	AST_RD_DATA: assert property (!rdStart |=> $stable(rdData_q))
		else $error("read data changed without a start");
	AST_BLOCK_RD: assert property (!mainPowerGood && !rdReady_q |=> !rdReady_q)
		else $error("read accepted while blocked");
	AST_BLOCK_FLAG: assert property (accessBlocked != mainPowerGood)
		else $error("blocked status wrong");
	AST_TICK_PULSE: assert property (tickIrq_q |=> !tickIrq_q [*8])
		else $error("tick pulse too long or too close");
	AST_ALARM_STICKY: assert property (alarmIrq_q && !flagClr |=> alarmIrq_q)
		else $error("alarm line dropped without clear");
endmodule

bind bcrtc_core bcrtc_core_properties bcrtc_core_properties_i (.clk(clk), .reset(reset),
	.mainPowerGood(mainPowerGood), .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData),
	.rdStart(rdStart), .rdTake(rdTake), .rdData_q(rdData_q), .rdReady_q(rdReady_q),
	.accessBlocked(accessBlocked), .alarmIrq_q(alarmIrq_q), .tickIrq_q(tickIrq_q));

// >>> sim/bcrtc_xtal_model.sv
// Crystal stand-in for the timebase input.
// Assumes clk is the system clock; period shortened to HI+LO clk cycles.
`timescale 1ns/1ps
module bcrtc_xtal_model #(
	parameter HI = 2,
	parameter LO = 1
) (
	// Clock
	input  wire clk,
	// Control
	input  wire enable,
	// Crystal output
	output reg  xtalOut
);
	integer cnt = 0;
	initial xtalOut = 1'b0;
	// Stands still low while disabled
	always @(posedge clk) begin
		if (!enable) begin
			cnt <= 0;
			xtalOut <= 1'b0;
		end else if (cnt == (xtalOut ? HI : LO) - 1) begin
			cnt <= 0;
			xtalOut <= !xtalOut;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

// >>> sim/bcrtc_core_tb.sv
// Self-checking bench for bcrtc_core: host port, calendar, tick and alarm.
// Assumes the crystal stand-in runs at three clk cycles per period.
`timescale 1ns/1ps
module bcrtc_core_tb;
	localparam        P = 3;
	localparam [39:0] CAL_A = {5'h08, 5'h07, 5'h06, 5'h04, 5'h05, 5'h03, 5'h02, 5'h01};
	localparam [63:0] RST_V = {8'h20, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
	localparam [63:0] SET_V = {8'h20, 8'h24, 8'h02, 8'h28, 8'h07, 8'h23, 8'h59, 8'h59};
	localparam [63:0] NEW_V = {8'h20, 8'h24, 8'h02, 8'h29, 8'h01, 8'h00, 8'h00, 8'h00};
	reg        clk = 1'b0;
	reg        reset = 1'b1;
	reg        xtalEn = 1'b0;
	reg        mainPowerGood = 1'b1;
	reg        wrEn = 1'b0;
	reg  [4:0] wrAddr = 5'h00;
	reg  [7:0] wrData = 8'h00;
	reg        rdStart = 1'b0;
	reg        rdTake = 1'b0;
	reg  [4:0] rdAddr = 5'h00;
	wire       xtalIn;
	wire [7:0] rdData_q;
	wire       rdReady_q;
	wire       accessBlocked;
	wire       alarmIrq_q;
	wire       tickIrq_q;
	integer    errorCnt = 0;
	integer    numChecks = 0;
	integer    cycleCnt = 0;
	integer    i;
	integer    n;
	reg  [7:0] d;

	bcrtc_xtal_model #(.HI(2), .LO(1)) bcrtc_xtal_model_i (.clk(clk), .enable(xtalEn), .xtalOut(xtalIn));
	bcrtc_core bcrtc_core_i (.clk(clk), .reset(reset), .xtalIn(xtalIn), .mainPowerGood(mainPowerGood),
		.wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData), .rdStart(rdStart), .rdTake(rdTake),
		.rdAddr(rdAddr), .rdData_q(rdData_q), .rdReady_q(rdReady_q), .accessBlocked(accessBlocked),
		.alarmIrq_q(alarmIrq_q), .tickIrq_q(tickIrq_q));

	initial begin
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycleCnt = cycleCnt + 1;
		if (cycleCnt == 110000) begin
			errorCnt = errorCnt + 1;
			endSim;
		end
	end

	////////////////////////////////////////////////////////////////////////
	task endSim;
		$display("checks %0d errors %0d", numChecks, errorCnt);
		if (errorCnt == 0 && numChecks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		numChecks = numChecks + 1;
		if (got !== exp) begin
			errorCnt = errorCnt + 1;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task chkNum(input string what, input integer exp, input integer got);
		numChecks = numChecks + 1;
		if (got !== exp) begin
			errorCnt = errorCnt + 1;
			$display("BAD %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	task wr(input [4:0] a, input [7:0] v);
		@(negedge clk);
		wrEn = 1'b1;
		wrAddr = a;
		wrData = v;
		@(negedge clk);
		wrEn = 1'b0;
	endtask

	// Start, then collect one cycle later
	task rd(input [4:0] a, input ok, output [7:0] v);
		@(negedge clk);
		rdStart = 1'b1;
		rdAddr = a;
		@(negedge clk);
		rdStart = 1'b0;
		chk("ready", {7'h00, ok}, {7'h00, rdReady_q});
		v = rdData_q;
		rdTake = 1'b1;
		@(negedge clk);
		rdTake = 1'b0;
	endtask

	task readCal(input [63:0] e);
		integer k;
		integer pass;
		for (pass = 0; pass < 2; pass = pass + 1) begin
			for (k = 0; k < 8; k = k + 1) begin
				rd(CAL_A[39-5*k -: 5], 1'b1, d);
				chk("calendar", e[63-8*k -: 8], d);
			end
			// A zero second means a carry may have split the sequence: read it all again
			if (d !== 8'h00)
				pass = 1;
		end
	endtask

	task waitTick(output integer c);
		c = 1;
		@(negedge clk);
		while (tickIrq_q !== 1'b1 && c < 20000) begin
			@(negedge clk);
			c = c + 1;
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		rd(5'h00, 1'b0, d);
		wr(5'h00, 8'h03);
		rd(5'h00, 1'b1, d);
		chk("control", 8'h03, d);
		readCal(RST_V);
		rd(5'h1f, 1'b1, d);
		chk("unmapped", 8'h00, d);
		mainPowerGood = 1'b0;
		@(negedge clk);
		chk("blocked", 8'h01, {7'h00, accessBlocked});
		wr(5'h01, 8'h45);
		rd(5'h01, 1'b0, d);
		mainPowerGood = 1'b1;
		rd(5'h01, 1'b1, d);
		chk("seconds", 8'h00, d);
		wr(5'h00, 8'h02);
		for (i = 0; i < 8; i = i + 1)
			wr(CAL_A[39-5*i -: 5], SET_V[63-8*i -: 8]);
		wr(5'h09, 8'ha8);
		wr(5'h0d, 8'h29);
		wr(5'h0f, 8'h02);
		wr(5'h0a, 8'h33);
		wr(5'h00, 8'h03);
		xtalEn = 1'b1;
		for (i = 0; i < 3; i = i + 1) begin
			wr(5'h12, {3'h0, i[2:0], 2'b11});
			waitTick(n);
			waitTick(n);
			chkNum("tick period", (128 << (2 * i)) * P, n);
		end
		rd(5'h13, 1'b1, d);
		chk("tick flag", 8'h02, d & 8'h02);
		// Host blocked while the second rolls over: counters must keep running
		mainPowerGood = 1'b0;
		n = 0;
		while (alarmIrq_q !== 1'b1 && n < 100000) begin
			@(negedge clk);
			n = n + 1;
		end
		xtalEn = 1'b0;
		repeat (4) @(negedge clk);
		chk("alarm line", 8'h01, {7'h00, alarmIrq_q});
		mainPowerGood = 1'b1;
		@(negedge clk);
		chk("unblocked", 8'h00, {7'h00, accessBlocked});
		rd(5'h13, 1'b1, d);
		chk("alarm flag", 8'h01, d & 8'h01);
		readCal(NEW_V);
		wr(5'h13, 8'h01);
		@(negedge clk);
		chk("alarm cleared", 8'h00, {7'h00, alarmIrq_q});
		endSim;
	end
endmodule
